// ===== hdl/dvirx_pkg.sv
/*
  Constants shared by the pixel output port: pixel field layout, output
  clock timing and the operating states.
  Assumes a 40 MHz system clock driving the whole block.
*/
package dvirx_pkg;

  // Pixel layout
  localparam int unsigned PIX_W     = 24;
  localparam int unsigned COMP_W    = 8;
  localparam int unsigned BLUE_LSB  = 0;
  localparam int unsigned GREEN_LSB = 8;
  localparam int unsigned RED_LSB   = 16;
  localparam int unsigned CTL_W     = 2;

  // Timing
  localparam int unsigned SYS_PERIOD_NS  = 25;
  localparam int unsigned OCLK_PERIOD_NS = 200;
  localparam int unsigned OCLK_HALF_CYC  =
    OCLK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam int unsigned PH_W = 3;
  localparam logic [PH_W-1:0] PH_HALF = PH_W'(OCLK_HALF_CYC);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(2 * OCLK_HALF_CYC - 1);
  localparam logic [PH_W-1:0] PH_ZERO = 3'h0;

  // Pin synchroniser
  localparam int unsigned PIN_W = 3;
  localparam int unsigned PIN_CPD  = 0;
  localparam int unsigned PIN_ODPD = 1;
  localparam int unsigned PIN_PIX = 2;
  localparam logic [PIN_W-1:0] PIN_RST = 3'h3;

  localparam logic [PIX_W-1:0] PIX_ZERO = 24'h000000;

  typedef enum logic [1:0] {
    DVIRX_RUN   = 2'b01,
    DVIRX_SLEEP = 2'b10
  } dvirx_state_t;

endpackage : dvirx_pkg

// ===== hdl/dvirx_sync.sv
/*
  Two flip-flop synchroniser for a group of unrelated level pins.
  Assumes each bit is a slow level; no bus coherency across bits.
*/
`timescale 1ns/1ps
module dvirx_sync #(
  parameter int unsigned         W       = 1,
  parameter logic [W-1:0]        RST_VAL = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      meta_reg <= RST_VAL;
      pin_sync <= RST_VAL;
    end
    else
    begin
      meta_reg <= pin_in;
      pin_sync <= meta_reg;
    end
  end

endmodule : dvirx_sync

// ===== hdl/dvirx_port.sv
/*
  Pixel output port of a DVI receiver: takes decoded pixels and controls,
  presents them on an even and an odd 24-bit bus with sync, enable and
  control outputs, launched in step with a divided output pixel clock.
  Assumes the decoder delivers at most one pixel per output clock period
  in one-pixel mode and at most two in two-pixel mode, on clk_sys.
  Power-down and mode pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
module dvirx_port (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        chip_power_down_n,
  input  wire logic        output_drive_power_down_n,
  input  wire logic        pixels_per_clock_select,
  input  wire logic        in_valid,
  input  wire logic [7:0]  in_blue,
  input  wire logic [7:0]  in_green,
  input  wire logic [7:0]  in_red,
  input  wire logic        in_de,
  input  wire logic        in_hsync,
  input  wire logic        in_vsync,
  input  wire logic [1:0]  in_ctl,
  input  wire logic        in_sync_detect,
  output logic             pixel_out_clock,
  output logic             pixel_out_clock_oe_n,
  output logic [23:0]      even_pixel_bus,
  output logic             even_pixel_bus_oe_n,
  output logic [23:0]      odd_pixel_bus,
  output logic             odd_pixel_bus_oe_n,
  output logic             display_data_enable,
  output logic             display_data_enable_oe_n,
  output logic             hsync_out,
  output logic             hsync_out_oe_n,
  output logic             vsync_out,
  output logic             vsync_out_oe_n,
  output logic [1:0]       general_control_outputs,
  output logic             general_control_first_oe_n,
  output logic             general_control_second_oe_n,
  output logic             sync_detect_output,
  output logic             sync_detect_output_oe_n
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [dvirx_pkg::PIN_W-1:0] pins_raw;
  logic [dvirx_pkg::PIN_W-1:0] pins_s;

  assign pins_raw = {pixels_per_clock_select, output_drive_power_down_n,
                     chip_power_down_n};

  dvirx_sync #(
    .W       (dvirx_pkg::PIN_W),
    .RST_VAL (dvirx_pkg::PIN_RST)
  ) u_pin_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .pin_in   (pins_raw),
    .pin_sync (pins_s)
  );

  wire cpd_n_s  = pins_s[dvirx_pkg::PIN_CPD];
  wire odpd_n_s = pins_s[dvirx_pkg::PIN_ODPD];
  wire pix2_s  = pins_s[dvirx_pkg::PIN_PIX];

  ////////////////////////////////////////////////////////////////////////
  // State and output clock divider
  dvirx_pkg::dvirx_state_t        state_reg;
  dvirx_pkg::dvirx_state_t        state_next;
  logic [dvirx_pkg::PH_W-1:0]     ph_reg;
  logic [dvirx_pkg::PH_W-1:0]     ph_next;
  logic                           pix2_reg;
  logic                           odpd_n_reg;

  wire run    = (state_reg == dvirx_pkg::DVIRX_RUN);
  wire launch = run && (ph_reg == dvirx_pkg::PH_LAST);
  wire take   = run && in_valid;

  always_comb
  begin
    case (state_reg)
      dvirx_pkg::DVIRX_RUN:
        state_next = cpd_n_s ? dvirx_pkg::DVIRX_RUN
                             : dvirx_pkg::DVIRX_SLEEP;
      dvirx_pkg::DVIRX_SLEEP:
        state_next = cpd_n_s ? dvirx_pkg::DVIRX_RUN
                             : dvirx_pkg::DVIRX_SLEEP;
      default:
        state_next = dvirx_pkg::DVIRX_RUN;
    endcase
  end

  assign ph_next = !run    ? ph_reg :
                   launch  ? dvirx_pkg::PH_ZERO :
                   ph_reg + 3'h1;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_reg       <= dvirx_pkg::DVIRX_RUN;
      ph_reg          <= dvirx_pkg::PH_ZERO;
      pixel_out_clock <= 1'b0;
      pix2_reg        <= 1'b0;
      odpd_n_reg      <= 1'b1;
    end
    else
    begin
      state_reg       <= state_next;
      ph_reg          <= ph_next;
      pixel_out_clock <= (ph_next >= dvirx_pkg::PH_HALF);
      if (run)
      begin
        pix2_reg  <= pix2_s;
        odpd_n_reg <= odpd_n_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Staging of incoming pixels
  logic [dvirx_pkg::PIX_W-1:0]    even_stage_reg;
  logic [dvirx_pkg::PIX_W-1:0]    odd_stage_reg;
  logic                           par_reg;
  logic                           de_stage_reg;
  logic                           hs_stage_reg;
  logic                           vs_stage_reg;
  logic [dvirx_pkg::CTL_W-1:0]    ctl_stage_reg;

  wire [dvirx_pkg::PIX_W-1:0] in_pixel = {in_red, in_green, in_blue};
  wire to_even = take && in_de && (!pix2_reg || !par_reg);
  wire to_odd  = take && in_de && pix2_reg && par_reg;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      even_stage_reg <= dvirx_pkg::PIX_ZERO;
      odd_stage_reg  <= dvirx_pkg::PIX_ZERO;
      par_reg        <= 1'b0;
      de_stage_reg   <= 1'b0;
      hs_stage_reg   <= 1'b0;
      vs_stage_reg   <= 1'b0;
      ctl_stage_reg  <= 2'h0;
    end
    else if (take)
    begin
      par_reg       <= in_de ? !par_reg : 1'b0;
      de_stage_reg  <= in_de;
      hs_stage_reg  <= in_hsync;
      vs_stage_reg  <= in_vsync;
      ctl_stage_reg <= in_ctl;
      if (to_even)
        even_stage_reg <= in_pixel;
      if (to_odd)
        odd_stage_reg <= in_pixel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output launch and drivers
  wire rel_all = !run;
  wire rel_drv = !run || !odpd_n_reg;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      even_pixel_bus          <= dvirx_pkg::PIX_ZERO;
      odd_pixel_bus           <= dvirx_pkg::PIX_ZERO;
      display_data_enable     <= 1'b0;
      hsync_out               <= 1'b0;
      vsync_out               <= 1'b0;
      general_control_outputs <= 2'h0;
    end
    else if (launch)
    begin
      even_pixel_bus          <= even_stage_reg;
      odd_pixel_bus           <= pix2_reg ? odd_stage_reg
                                          : dvirx_pkg::PIX_ZERO;
      display_data_enable     <= de_stage_reg;
      hsync_out               <= hs_stage_reg;
      vsync_out               <= vs_stage_reg;
      general_control_outputs <= ctl_stage_reg;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sync_detect_output          <= 1'b0;
      pixel_out_clock_oe_n        <= 1'b0;
      even_pixel_bus_oe_n         <= 1'b0;
      odd_pixel_bus_oe_n          <= 1'b0;
      display_data_enable_oe_n    <= 1'b0;
      hsync_out_oe_n              <= 1'b0;
      vsync_out_oe_n              <= 1'b0;
      general_control_first_oe_n  <= 1'b0;
      general_control_second_oe_n <= 1'b0;
      sync_detect_output_oe_n     <= 1'b0;
    end
    else
    begin
      if (run)
        sync_detect_output <= in_sync_detect;
      pixel_out_clock_oe_n        <= rel_drv;
      even_pixel_bus_oe_n         <= rel_drv;
      odd_pixel_bus_oe_n          <= rel_drv;
      display_data_enable_oe_n    <= rel_drv;
      hsync_out_oe_n              <= rel_drv;
      vsync_out_oe_n              <= rel_drv;
      general_control_second_oe_n <= rel_drv;
      general_control_first_oe_n  <= rel_all;
      sync_detect_output_oe_n     <= rel_all;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  launch_only_a: assert property (
    !launch |=> $stable(even_pixel_bus) && $stable(odd_pixel_bus)
                && $stable(display_data_enable))
    else $error("Outputs moved outside launch");

  sleep_release_a: assert property (
    !cpd_n_s ##1 !cpd_n_s |=> even_pixel_bus_oe_n && odd_pixel_bus_oe_n
      && general_control_first_oe_n && sync_detect_output_oe_n
      && pixel_out_clock_oe_n)
    else $error("Outputs driven during power down");

  sleep_ignore_a: assert property (
    !run |=> $stable(even_stage_reg) && $stable(ph_reg)
             && $stable(pix2_reg) && $stable(sync_detect_output))
    else $error("Input acted on during power down");

  drive_release_a: assert property (
    run && !odpd_n_reg |=> even_pixel_bus_oe_n && hsync_out_oe_n
      && general_control_second_oe_n && !general_control_first_oe_n
      && !sync_detect_output_oe_n)
    else $error("Drive power down release wrong");

  pair_out_a: assert property (
    launch && pix2_reg |=> odd_pixel_bus == $past(odd_stage_reg)
                           && even_pixel_bus == $past(even_stage_reg))
    else $error("Pixel pair not launched together");

  one_pix_a: assert property (
    to_even && !pix2_reg && !launch ##1 !take [*2] ##0 launch
      |=> even_pixel_bus == $past(in_pixel, 3))
    else $error("Single pixel not on even bus");

  line_parity_a: assert property (
    take && !in_de |=> !par_reg)
    else $error("Parity not restarted on blank");

  blue_map_a: assert property (
    to_even |=> even_stage_reg[dvirx_pkg::BLUE_LSB +: dvirx_pkg::COMP_W]
                == $past(in_blue))
    else $error("Blue lane misplaced");

  green_map_a: assert property (
    to_even |=> even_stage_reg[dvirx_pkg::GREEN_LSB +: dvirx_pkg::COMP_W]
                == $past(in_green))
    else $error("Green lane misplaced");

  red_map_a: assert property (
    to_even |=> even_stage_reg[dvirx_pkg::RED_LSB +: dvirx_pkg::COMP_W]
                == $past(in_red))
    else $error("Red lane misplaced");

  odd_low_a: assert property (
    launch && !pix2_reg |=> odd_pixel_bus == dvirx_pkg::PIX_ZERO)
    else $error("Odd bus not low in one pixel mode");

endmodule : dvirx_port

// ===== sim/dvirx_panel.sv
/*
  Panel-side model of the pixel output port: latches both buses and the
  data enable on each rising edge of the output pixel clock.
  Assumes released lines fall to low through the weak pull-downs.
*/
`timescale 1ns/1ps
module dvirx_panel (
  input  wire logic        pixel_out_clock,
  input  wire logic [23:0] even_pixel_bus,
  input  wire logic        even_pixel_bus_oe_n,
  input  wire logic [23:0] odd_pixel_bus,
  input  wire logic        odd_pixel_bus_oe_n,
  input  wire logic        display_data_enable,
  input  wire logic        display_data_enable_oe_n,
  output logic      [23:0] cap_even,
  output logic      [23:0] cap_odd,
  output logic             cap_de
);
  initial
  begin
    cap_even = 24'h000000;
    cap_odd  = 24'h000000;
    cap_de   = 1'b0;
  end
  // Released lines read low
  always @(posedge pixel_out_clock)
  begin
    cap_even <= even_pixel_bus_oe_n ? 24'h000000 : even_pixel_bus;
    cap_odd  <= odd_pixel_bus_oe_n ? 24'h000000 : odd_pixel_bus;
    cap_de   <= display_data_enable_oe_n ? 1'b0 : display_data_enable;
  end
endmodule : dvirx_panel

// ===== sim/dvirx_port_tb.sv
/*
  Self-checking bench for the pixel output port with a panel model.
  Assumes a 40 MHz clock and pins driven 1 ns after the rising edge.
*/
`timescale 1ns/1ps
module dvirx_port_tb;
  logic        clk_sys, sys_rst, cpd_n, odpd_n, pix, in_valid, in_de, sd;
  logic        in_hs, in_vs, ock_pin;
  logic [7:0]  in_blue, in_green, in_red;
  logic [1:0]  in_ctl;
  logic        ock, ock_oe_n, ev_oe_n, od_oe_n, de, de_oe_n, hs, hs_oe_n;
  logic        vs, vs_oe_n, c1_oe_n, c2_oe_n, sdo, sd_oe_n, cap_de;
  logic [23:0] ev, od, cap_even, cap_odd;
  logic [1:0]  ctl;
  int          fails, cmp_count, cyc;

  dvirx_port dvirx_port_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .chip_power_down_n(cpd_n), .output_drive_power_down_n(odpd_n),
    .pixels_per_clock_select(pix), .in_valid(in_valid),
    .in_blue(in_blue), .in_green(in_green), .in_red(in_red),
    .in_de(in_de), .in_hsync(in_hs), .in_vsync(in_vs), .in_ctl(in_ctl),
    .in_sync_detect(sd), .pixel_out_clock(ock),
    .pixel_out_clock_oe_n(ock_oe_n), .even_pixel_bus(ev),
    .even_pixel_bus_oe_n(ev_oe_n), .odd_pixel_bus(od),
    .odd_pixel_bus_oe_n(od_oe_n), .display_data_enable(de),
    .display_data_enable_oe_n(de_oe_n), .hsync_out(hs),
    .hsync_out_oe_n(hs_oe_n), .vsync_out(vs), .vsync_out_oe_n(vs_oe_n),
    .general_control_outputs(ctl), .general_control_first_oe_n(c1_oe_n),
    .general_control_second_oe_n(c2_oe_n), .sync_detect_output(sdo),
    .sync_detect_output_oe_n(sd_oe_n));

  // Released clock line reads low
  assign ock_pin = ock & ~ock_oe_n;

  dvirx_panel dvirx_panel_i (.pixel_out_clock(ock_pin), .even_pixel_bus(ev),
    .even_pixel_bus_oe_n(ev_oe_n), .odd_pixel_bus(od),
    .odd_pixel_bus_oe_n(od_oe_n), .display_data_enable(de),
    .display_data_enable_oe_n(de_oe_n), .cap_even(cap_even),
    .cap_odd(cap_odd), .cap_de(cap_de));

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string n, input logic [23:0] e,
                     input logic [23:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic test_done();
    $display("Checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  // Returns just after a rising edge of the output clock
  task automatic wait_rise();
    wait (ock === 1'b0);
    wait (ock === 1'b1);
  endtask : wait_rise

  task automatic send(input logic [23:0] p, input logic d);
    @(posedge clk_sys);
    #1;
    {in_red, in_green, in_blue} = p;
    in_de    = d;
    in_ctl   = ~in_ctl;
    in_hs    = in_ctl[0];
    in_vs    = ~in_ctl[1];
    in_valid = 1'b1;
  endtask : send

  task automatic idle();
    @(posedge clk_sys);
    #1;
    in_valid = 1'b0;
  endtask : idle

  task automatic t_one_pixel();
    wait_rise();
    send(24'h332211, 1'b1);
    idle();
    wait_rise();
    #1;
    chk("even bus", 24'h332211, cap_even);
    chk("odd bus", 24'h000000, cap_odd);
    chk("enable", 24'h000001, {23'h0, cap_de});
    chk("ctl", {22'h0, in_ctl}, {22'h0, ctl});
    chk("hsync", {23'h0, in_hs}, {23'h0, hs});
    chk("vsync", {23'h0, in_vs}, {23'h0, vs});
    send(24'h665544, 1'b1);
    idle();
    wait_rise();
    #1;
    chk("even bus odd pixel", 24'h665544, cap_even);
    chk("odd bus", 24'h000000, cap_odd);
    $display("Test one pixel done");
  endtask : t_one_pixel

  task automatic t_two_pixel();
    pix = 1'b1;
    repeat (3) wait_rise();
    send(24'h000000, 1'b0);
    idle();
    wait_rise();
    send(24'hc3b2a1, 1'b1);
    send(24'hf6e5d4, 1'b1);
    idle();
    wait_rise();
    #1;
    chk("pair even", 24'hc3b2a1, cap_even);
    chk("pair odd", 24'hf6e5d4, cap_odd);
    send(24'h123456, 1'b1);
    send(24'h000000, 1'b0);
    idle();
    wait_rise();
    send(24'h9a8b7c, 1'b1);
    idle();
    wait_rise();
    #1;
    chk("new line even", 24'h9a8b7c, cap_even);
    $display("Test two pixel done");
  endtask : t_two_pixel

  task automatic t_power();
    odpd_n = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    chk("drv even oe", 24'h000001, {23'h0, ev_oe_n});
    chk("drv other oes", 24'h00001f, {19'h0, od_oe_n, ock_oe_n, de_oe_n,
        hs_oe_n, vs_oe_n});
    chk("drv ctl2 oe", 24'h000001, {23'h0, c2_oe_n});
    chk("drv general_control_first oe", 24'h000000, {23'h0, c1_oe_n});
    chk("drv sd oe", 24'h000000, {23'h0, sd_oe_n});
    odpd_n = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    chk("run even oe", 24'h000000, {23'h0, ev_oe_n});
    cpd_n = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    chk("sleep oes", 24'h0001ff, {15'h0, ev_oe_n, od_oe_n, c1_oe_n, sd_oe_n,
        ock_oe_n, de_oe_n, hs_oe_n, vs_oe_n, c2_oe_n});
    sd = 1'b0;
    send(24'h0f0f0f, 1'b1);
    idle();
    chk("sleep sd hold", 24'h000001, {23'h0, sdo});
    cpd_n = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    wait_rise();
    #1;
    chk("sleep ignores input", 24'h9a8b7c, ev);
    chk("wake sd", 24'h000000, {23'h0, sdo});
    chk("wake sd oe", 24'h000000, {23'h0, sd_oe_n});
    $display("Test power done");
  endtask : t_power

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      test_done();
    end
  end

  initial
  begin
    {sys_rst, cpd_n, odpd_n, sd} = 4'hf;
    {pix, in_valid, in_de, in_hs, in_vs} = 5'h00;
    {in_blue, in_green, in_red, in_ctl} = '0;
    repeat (6) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    t_one_pixel();
    t_two_pixel();
    t_power();
    test_done();
  end
endmodule : dvirx_port_tb
